// ===== ihp_dev.sv
// Device end of the ISA host port: decode, strobes, ready, DMA, interrupts, straps.
// Assumes host pins are synchronous to mclk_i; rst_i acts as the device reset, host_reset is not used.
// Summary of operation
// - Decode low twelve address bits on I/O cycles.
// - Upper address must be zero when used.
// - Low clock strap turns upper pins to CDROM.
// - Address enable low means I/O, high DMA.
// - Read strobe returns register or DMA byte.
// - Write strobe stores register or DMA byte.
// - Pull ready low until data is ready.
// - DMA request holds until transfer bytes moved.
// - DMA pairs go to 8-bit channels 0,1,3.
// - Acknowledge latches write byte or drives read byte.
// - Interrupt outputs individually enabled by configuration.
// - Reset high keeps device reset and powered down.
// - First enabled clock after reset falls latches strap pin levels.
// - Buffered reset output low while reset high.
// - General output zero follows codec index ten bit.
// - Drive data bus only on own reads.
// - Host waits 200 ms after reset before writing.
// - Config port 279, 308 or 388 by straps.
`timescale 1ns/10ps
module ihp_dev (
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   ihp_if.dev              bus,
   input  wire logic       strap_clk_i,
   input  wire logic       strap_sclk_i,
   input  wire logic       strap_eeclk_i,
   input  wire logic       port_select_strap_i,
   input  wire logic [2:0] dma_need_i,
   input  wire logic [7:0] dma_rd_byte_i,
   input  wire logic [6:0] irq_event_i,
   output logic      [7:0] dma_wr_byte_o,
   output logic      [2:0] dma_wr_stb_o,
   output logic      [2:0] dma_rd_stb_o,
   output logic            cdrom_mode_o,
   output logic            powered_down_o
);
   logic [11:0] base_a_q;       // Register block base
   logic [11:0] base_b_q;       // Data window base
   logic [11:0] cfg_port_q;
   logic [7:0]  codec_index_ten_q;
   logic [7:0]  idx_q;
   logic [7:0]  rdata_q;
   logic        upper_addr_q;
   logic        strap_pend_q;
   logic [6:0]  irq_en_q;
   logic [2:0]  drq_q;
   logic        rd_oe_q;
   logic        rdy_oe_q;
   logic [2:0]  wcnt_q;
   ihp_pkg::ihp_cyc_t st_q;

   // Address decode, combinational for speed
   wire         io_cyc   = ~bus.aen;
   wire         upper_ok = ~upper_addr_q | (bus.addr[15:12] == ihp_pkg::UPPER_ZERO);
   wire         hit_cfg  = io_cyc & upper_ok & (bus.addr[11:0] == cfg_port_q);
   wire         hit_a    = io_cyc & upper_ok & (bus.addr[11:1] == base_a_q[11:1]);
   wire         hit_b    = io_cyc & upper_ok & (bus.addr[11:0] == base_b_q);
   wire         hit_io   = hit_cfg | hit_a | hit_b;
   wire [2:0]   dack     = ~bus.dack_n & {3{bus.aen}};
   wire         dma_act  = |dack;
   wire         rd_act   = ~bus.rd_n;
   wire         wr_act   = ~bus.wr_n;
   wire         rd_start = rd_act & (hit_io | dma_act) & (st_q == ihp_pkg::IHP_IDLE);
   wire         wr_io    = wr_act & hit_io & ~dma_act;
   wire         wr_dma   = wr_act & dma_act;
   wire [7:0]   reg_rd   = hit_cfg ? cfg_port_q[7:0] :
                           (hit_a & ~bus.addr[0]) ? idx_q :
                           hit_a ? (idx_q == 8'h0A ? codec_index_ten_q : {1'b0, irq_en_q}) :
                           {drq_q, 1'b0, upper_addr_q, 3'h0};
   wire [7:0]   rd_val   = dma_act ? dma_rd_byte_i : reg_rd;

   // Strap capture on the clock after reset release; never in the async branch
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         strap_pend_q <= 1'b1;
         upper_addr_q <= 1'b1;
         cfg_port_q   <= ihp_pkg::CFG_PORT_STD;
      end else if (ce_i && strap_pend_q) begin
         strap_pend_q <= 1'b0;
         upper_addr_q <= strap_clk_i & strap_sclk_i;
         cfg_port_q   <= port_select_strap_i ? ihp_pkg::CFG_PORT_STD :
                         (strap_eeclk_i ? ihp_pkg::CFG_PORT_ALT_H : ihp_pkg::CFG_PORT_ALT_L);
      end
   end

   // Control registers written over I/O cycles
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         base_a_q          <= ihp_pkg::BASE_A_RST;
         base_b_q          <= ihp_pkg::BASE_B_RST;
         idx_q             <= 8'h00;
         codec_index_ten_q <= 8'h00;
         irq_en_q          <= ihp_pkg::IRQ_EN_RST;
      end else if (ce_i && wr_io && st_q == ihp_pkg::IHP_IDLE) begin
         if (hit_a && !bus.addr[0]) begin
            idx_q <= bus.host_data;
         end else if (hit_a && idx_q == 8'h0A) begin
            codec_index_ten_q <= bus.host_data;
         end else if (hit_a) begin
            irq_en_q <= bus.host_data[6:0];
         end else if (hit_cfg) begin
            base_b_q <= {bus.host_data, 4'h0};
         end
      end
   end

   // Read cycle: hold ready low for a few cycles, then present data
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q     <= ihp_pkg::IHP_IDLE;
         wcnt_q   <= 3'h0;
         rdy_oe_q <= 1'b0;
         rd_oe_q  <= 1'b0;
         rdata_q  <= 8'h00;
      end else if (ce_i) begin
         case (st_q)
            ihp_pkg::IHP_IDLE: begin
               if (rd_start) begin
                  st_q     <= ihp_pkg::IHP_WAIT;
                  wcnt_q   <= ihp_pkg::WAIT_CYC;
                  rdy_oe_q <= 1'b1;
               end
            end
            ihp_pkg::IHP_WAIT: begin
               if (!rd_act) begin
                  st_q     <= ihp_pkg::IHP_IDLE;
                  rdy_oe_q <= 1'b0;
               end else if (wcnt_q == 3'h0) begin
                  st_q     <= ihp_pkg::IHP_DONE;
                  rdy_oe_q <= 1'b0;
                  rdata_q  <= rd_val;
                  rd_oe_q  <= 1'b1;
               end else begin
                  wcnt_q <= wcnt_q - 3'h1;
               end
            end
            default: begin
               if (!rd_act) begin
                  st_q    <= ihp_pkg::IHP_IDLE;
                  rd_oe_q <= 1'b0;
               end
            end
         endcase
      end
   end

   // DMA requests, write latch and interrupt pins
   logic [7:0] dwr_q;
   logic [2:0] dwstb_q;
   logic [2:0] drstb_q;
   logic [6:0] irq_q;
   logic [6:0] irq_oe_q;
   logic       bres_n_q;
   logic       gpo_q;
   logic       pd_q;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         drq_q    <= 3'h0;
         dwr_q    <= 8'h00;
         dwstb_q  <= 3'h0;
         drstb_q  <= 3'h0;
         irq_q    <= 7'h00;
         irq_oe_q <= 7'h00;
         bres_n_q <= 1'b0;
         gpo_q    <= 1'b0;
         pd_q     <= 1'b1;
      end else if (ce_i) begin
         drq_q    <= dma_need_i;
         dwstb_q  <= (wr_dma && st_q == ihp_pkg::IHP_IDLE) ? dack : 3'h0;
         if (wr_dma) begin
            dwr_q <= bus.host_data;
         end
         drstb_q  <= (rd_start && dma_act) ? dack : 3'h0;
         irq_q    <= irq_event_i & irq_en_q;
         irq_oe_q <= irq_en_q;
         bres_n_q <= 1'b1;
         gpo_q    <= codec_index_ten_q[ihp_pkg::GPO_BIT];
         pd_q     <= 1'b0;
      end
   end

   assign bus.dev_data             = rdata_q;
   assign bus.dev_data_oe          = rd_oe_q;
   assign bus.rdy_oe               = rdy_oe_q;
   assign bus.drq                  = drq_q;
   assign bus.irq                  = irq_q;
   assign bus.irq_oe               = irq_oe_q;
   assign bus.buffered_reset_out_n = bres_n_q;
   assign bus.general_output_zero  = gpo_q;
   assign dma_wr_byte_o            = dwr_q;
   assign dma_wr_stb_o             = dwstb_q;
   assign dma_rd_stb_o             = drstb_q;
   assign cdrom_mode_o             = ~upper_addr_q;
   assign powered_down_o           = pd_q;
endmodule

// ===== ihp_pkg.sv
// Package for the ISA host port: decode constants, strap encodings, timing counts.
// Assumes a single 100 MHz clock shared by both ends.
package ihp_pkg;
   localparam int          CLK_MHZ        = 100;
   localparam int          SETTLE_MS      = 200;
   localparam int          SETTLE_CYC     = SETTLE_MS * 1000 * CLK_MHZ;
   localparam logic [11:0] CFG_PORT_STD   = 12'h279;
   localparam logic [11:0] CFG_PORT_ALT_H = 12'h308;
   localparam logic [11:0] CFG_PORT_ALT_L = 12'h388;
   localparam logic [11:0] BASE_A_RST     = 12'h534;
   localparam logic [11:0] BASE_B_RST     = 12'h220;
   localparam logic [3:0]  UPPER_ZERO     = 4'h0;
   localparam logic [2:0]  WAIT_CYC       = 3'h3;
   localparam logic [6:0]  IRQ_EN_RST     = 7'h3F;
   localparam int          N_DMA          = 3;
   localparam int          N_IRQ          = 7;
   localparam int          GPO_BIT        = 6;
   typedef enum logic [1:0] {
      IHP_IDLE = 2'h0,
      IHP_WAIT = 2'h1,
      IHP_DONE = 2'h3
   } ihp_cyc_t;
endpackage

// ===== ihp_if.sv
// Interface joining the host end and the device end of the ISA port.
// Assumes the testbench resolves shared wires from the output enables.
`timescale 1ns/10ps
interface ihp_if;
   logic [15:0] addr;
   logic        aen;
   logic        rd_n;
   logic        wr_n;
   logic [7:0]  host_data;
   logic        host_data_oe;
   logic [7:0]  dev_data;
   logic        dev_data_oe;
   logic        rdy_oe;
   logic [2:0]  drq;
   logic [2:0]  dack_n;
   logic [6:0]  irq;
   logic [6:0]  irq_oe;
   logic        host_reset;
   logic        buffered_reset_out_n;
   logic        general_output_zero;
   modport dev  (input addr, aen, rd_n, wr_n, host_data, host_data_oe, dack_n, host_reset,
                 output dev_data, dev_data_oe, rdy_oe, drq, irq, irq_oe,
                 buffered_reset_out_n, general_output_zero);
   modport host (output addr, aen, rd_n, wr_n, host_data, host_data_oe, dack_n, host_reset,
                 input dev_data, dev_data_oe, rdy_oe, drq, irq, irq_oe,
                 buffered_reset_out_n, general_output_zero);
endinterface

// ===== ihp_host.sv
// Host end: runs single I/O or DMA cycles on request, stretched by the ready line.
// Assumes the device end shares mclk_i; the host drives reset to the device.
`timescale 1ns/10ps
module ihp_host #(
   parameter int SETTLE = ihp_pkg::SETTLE_CYC
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   ihp_if.host              bus,
   input  wire logic        req_i,
   input  wire logic        req_wr_i,
   input  wire logic        req_dma_i,
   input  wire logic [1:0]  req_chan_i,
   input  wire logic [15:0] req_addr_i,
   input  wire logic [7:0]  req_wdata_i,
   output logic             busy_o,
   output logic             done_o,
   output logic      [7:0]  rdata_o,
   output logic             ready_o
);
   logic [31:0] settle_q;
   logic        busy_q;
   logic        done_q;
   logic        strobe_q;
   logic        wr_q;
   logic        dma_q;
   logic [2:0]  dack_n_q;
   logic [15:0] addr_q;
   logic [7:0]  wdata_q;
   logic [7:0]  rdata_q;
   logic        ready_q;
   logic        age_q;

   wire         settled = (settle_q == 32'h0);
   wire         go      = req_i & ~busy_q & settled;
   // A read nobody claims ends after the minimum cycle instead of hanging
   wire         rd_over    = bus.dev_data_oe | age_q;
   wire         release_ok = strobe_q & ~bus.rdy_oe & (wr_q | rd_over);

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         settle_q <= 32'(SETTLE);
         age_q    <= 1'b0;
         busy_q   <= 1'b0;
         done_q   <= 1'b0;
         strobe_q <= 1'b0;
         wr_q     <= 1'b0;
         dma_q    <= 1'b0;
         dack_n_q <= 3'h7;
         addr_q   <= 16'h0000;
         wdata_q  <= 8'h00;
         rdata_q  <= 8'h00;
         ready_q  <= 1'b0;
      end else if (ce_i) begin
         ready_q <= settled;
         age_q   <= strobe_q;
         done_q  <= 1'b0;
         if (!settled) begin
            settle_q <= settle_q - 32'h1;
         end
         if (go) begin
            busy_q   <= 1'b1;
            strobe_q <= 1'b1;
            wr_q     <= req_wr_i;
            dma_q    <= req_dma_i;
            addr_q   <= req_addr_i;
            wdata_q  <= req_wdata_i;
            dack_n_q <= req_dma_i ? ~(3'h1 << req_chan_i) : 3'h7;
         end else if (release_ok) begin
            strobe_q <= 1'b0;
            busy_q   <= 1'b0;
            done_q   <= 1'b1;
            dack_n_q <= 3'h7;
            if (!wr_q) begin
               rdata_q <= bus.dev_data;
            end
         end
      end
   end

   // Device reset lifts one clock after the host's own
   logic rst_seen_q;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rst_seen_q <= 1'b0;
      end else if (ce_i) begin
         rst_seen_q <= 1'b1;
      end
   end

   assign bus.addr         = addr_q;
   assign bus.aen          = dma_q;
   assign bus.rd_n         = ~(strobe_q & ~wr_q);
   assign bus.wr_n         = ~(strobe_q & wr_q);
   assign bus.host_data    = wdata_q;
   assign bus.host_data_oe = strobe_q & wr_q;
   assign bus.dack_n       = dack_n_q;
   assign bus.host_reset   = ~rst_seen_q;
   assign busy_o           = busy_q;
   assign done_o           = done_q;
   assign rdata_o          = rdata_q;
   assign ready_o          = ready_q;
endmodule

// ===== ihp_chk.sv
// Checker for the wires between the two ends of the ISA host port.
// Assumes one clock domain; rst_i resets both ends.
`timescale 1ns/10ps
module ihp_chk (
   input wire logic       mclk_i,
   input wire logic       rst_i,
   input wire logic       aen,
   input wire logic       rd_n,
   input wire logic       wr_n,
   input wire logic       host_data_oe,
   input wire logic       dev_data_oe,
   input wire logic       rdy_oe,
   input wire logic [2:0] dack_n,
   input wire logic       host_reset,
   input wire logic       buffered_reset_out_n
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // Stretch length is fixed by the wait countdown plus one
   sequence s_stretch;
      rdy_oe [*4] ##1 (!rdy_oe && dev_data_oe);
   endsequence
   sequence s_rd_cause;
      aen ? (dack_n != 3'h7) : !rd_n;
   endsequence
   AST_BRES_LOW: assert property (host_reset |-> !buffered_reset_out_n)
      else $error("buffered reset high while reset held");
   AST_BRES_UP: assert property ($fell(host_reset) |-> ##[0:2] buffered_reset_out_n)
      else $error("buffered reset not released");
   AST_RD_DRIVE: assert property (dev_data_oe |-> !$past(rd_n))
      else $error("data driven outside a read");
   AST_RDY_WALK: assert property ($rose(rdy_oe) |-> s_stretch)
      else $error("ready stretch length wrong");
   AST_RDY_CAUSE: assert property ($rose(rdy_oe) |-> $past(!rd_n))
      else $error("ready pulled without a read");
   AST_OE_CAUSE: assert property ($rose(dev_data_oe) |-> s_rd_cause)
      else $error("data driven without io read or acknowledge");
   AST_WR_NO_DRIVE: assert property (!wr_n |-> !dev_data_oe)
      else $error("data driven during a write");
   AST_DATA_EXCL: assert property (!(dev_data_oe && host_data_oe))
      else $error("both ends drive data");
   AST_WR_NO_RDY: assert property (!wr_n |-> !rdy_oe)
      else $error("write stretched");
endmodule

// ===== tb.sv
// Testbench joining host end and device end through the port interface.
// Assumes a short settle count so the run stays brief.
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
   $display("ERROR %0t: got %0h expected %0h", $time, got, exp); end end
module tb;
   logic        mclk_i, rst_i, req_i, req_wr_i, req_dma_i, oe_seen;
   logic [1:0]  req_chan_i;
   logic [15:0] req_addr_i;
   logic [7:0]  req_wdata_i, rdata_o, dma_rd_byte_i, dma_wr_byte_o;
   logic        busy_o, done_o, ready_o, cdrom_mode_o, powered_down_o;
   logic        strap_clk_i, strap_sclk_i, strap_eeclk_i, port_select_strap_i, ce_i;
   logic [2:0]  dma_need_i, dma_wr_stb_o, dma_rd_stb_o, wstb, rstb;
   logic [6:0]  irq_event_i;
   int          n_errors, checks_done, cyc_cnt;
   ihp_if bus_if ();
   ihp_dev ihp_dev_i (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .bus(bus_if),
      .strap_clk_i(strap_clk_i), .strap_sclk_i(strap_sclk_i), .strap_eeclk_i(strap_eeclk_i),
      .port_select_strap_i(port_select_strap_i), .dma_need_i(dma_need_i),
      .dma_rd_byte_i(dma_rd_byte_i), .irq_event_i(irq_event_i), .dma_wr_byte_o(dma_wr_byte_o),
      .dma_wr_stb_o(dma_wr_stb_o), .dma_rd_stb_o(dma_rd_stb_o), .cdrom_mode_o(cdrom_mode_o),
      .powered_down_o(powered_down_o));
   ihp_host #(.SETTLE(16)) ihp_host_i (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
      .bus(bus_if), .req_i(req_i), .req_wr_i(req_wr_i), .req_dma_i(req_dma_i),
      .req_chan_i(req_chan_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
      .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .ready_o(ready_o));
   ihp_chk ihp_chk_i (.mclk_i(mclk_i), .rst_i(rst_i), .aen(bus_if.aen), .rd_n(bus_if.rd_n),
      .wr_n(bus_if.wr_n), .host_data_oe(bus_if.host_data_oe), .dev_data_oe(bus_if.dev_data_oe),
      .rdy_oe(bus_if.rdy_oe), .dack_n(bus_if.dack_n), .host_reset(bus_if.host_reset),
      .buffered_reset_out_n(bus_if.buffered_reset_out_n));
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   // Sticky capture, since strobes last one cycle
   always @(posedge mclk_i) begin
      wstb <= wstb | dma_wr_stb_o;
      rstb <= rstb | dma_rd_stb_o;
      oe_seen <= oe_seen | bus_if.dev_data_oe;
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 3000) begin
         n_errors++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cyc(input logic w, d, input logic [1:0] ch, input logic [15:0] a,
                      input logic [7:0] wd);
      int k;
      k = 0;
      while (!(ready_o === 1'b1 && busy_o === 1'b0) && k < 100) begin
         @(negedge mclk_i);
         k++;
      end
      // Clear here so the tail of the previous read cannot leak in
      {wstb, rstb, oe_seen} = '0;
      {req_wr_i, req_dma_i, req_chan_i, req_addr_i, req_wdata_i} <= {w, d, ch, a, wd};
      req_i <= 1'b1;
      @(negedge mclk_i);
      req_i <= 1'b0;
      k = 0;
      while (done_o !== 1'b1 && k < 100) begin
         @(negedge mclk_i);
         k++;
      end
      `CHK(k < 100, 1'b1)
      repeat (2) @(negedge mclk_i);
   endtask
   task automatic do_reset(input logic [3:0] s);
      {strap_clk_i, port_select_strap_i, strap_eeclk_i, strap_sclk_i} <= s;
      rst_i <= 1'b1;
      repeat (20) @(negedge mclk_i);
      `CHK(bus_if.buffered_reset_out_n, 1'b0)
      `CHK(powered_down_o, 1'b1)
      rst_i <= 1'b0;
      repeat (3) @(negedge mclk_i);
      // Flip the pins to prove the levels were latched
      {strap_clk_i, port_select_strap_i, strap_eeclk_i, strap_sclk_i} <= ~s;
      `CHK(ready_o, 1'b0)
      `CHK(powered_down_o, 1'b0)
      `CHK(bus_if.buffered_reset_out_n, 1'b1)
      `CHK(cdrom_mode_o, ~(s[3] & s[0]))
   endtask
   initial begin
      logic [3:0]  tab [4];
      logic [11:0] port [4];
      // Strap order: clock, port select, eeprom clock, serial clock
      tab = '{4'b1111, 4'b0011, 4'b1001, 4'b1100};
      port = '{ihp_pkg::CFG_PORT_STD, ihp_pkg::CFG_PORT_ALT_H, ihp_pkg::CFG_PORT_ALT_L,
               ihp_pkg::CFG_PORT_STD};
      {rst_i, req_i, req_wr_i, req_dma_i, req_chan_i, req_addr_i, req_wdata_i} = '0;
      {dma_need_i, dma_rd_byte_i, irq_event_i, wstb, rstb, oe_seen, cyc_cnt} = '0;
      {strap_clk_i, strap_eeclk_i, port_select_strap_i, n_errors, checks_done} = '0;
      strap_sclk_i = 1'b0;
      ce_i = 1'b1;
      for (int i = 3; i >= 0; i--) begin
         do_reset(tab[i]);
         cyc(1'b0, 1'b0, 2'h0, {4'h0, port[i]}, 8'h00);
         `CHK(rdata_o, port[i][7:0])
      end
      cyc(1'b0, 1'b0, 2'h0, 16'h1279, 8'h00);
      `CHK(oe_seen, 1'b0)
      cyc(1'b0, 1'b0, 2'h0, 16'h0300, 8'h00);
      `CHK(oe_seen, 1'b0)
      cyc(1'b1, 1'b0, 2'h0, 16'h0534, 8'h0A);
      cyc(1'b1, 1'b0, 2'h0, 16'h0535, 8'h40);
      `CHK(bus_if.general_output_zero, 1'b1)
      cyc(1'b1, 1'b0, 2'h0, 16'h0535, 8'hBF);
      `CHK(bus_if.general_output_zero, 1'b0)
      irq_event_i <= 7'h7F;
      repeat (3) @(negedge mclk_i);
      `CHK(bus_if.irq_oe, ihp_pkg::IRQ_EN_RST)
      `CHK(bus_if.irq & bus_if.irq_oe, 7'h3F)
      cyc(1'b1, 1'b0, 2'h0, 16'h0534, 8'h01);
      cyc(1'b1, 1'b0, 2'h0, 16'h0535, 8'h41);
      irq_event_i <= 7'h01;
      repeat (3) @(negedge mclk_i);
      `CHK(bus_if.irq_oe, 7'h41)
      `CHK(bus_if.irq & bus_if.irq_oe, 7'h01)
      // Clock enable low must freeze the pins
      ce_i <= 1'b0;
      irq_event_i <= 7'h40;
      repeat (3) @(negedge mclk_i);
      `CHK(bus_if.irq & bus_if.irq_oe, 7'h01)
      ce_i <= 1'b1;
      repeat (3) @(negedge mclk_i);
      `CHK(bus_if.irq & bus_if.irq_oe, 7'h40)
      for (int c = 0; c < 3; c++) begin
         dma_need_i <= 3'h1 << c;
         dma_rd_byte_i <= 8'h5C ^ 8'(c);
         repeat (3) @(negedge mclk_i);
         `CHK(bus_if.drq, 3'h1 << c)
         cyc(1'b1, 1'b1, 2'(c), 16'h0000, 8'hA0 + 8'(c));
         `CHK(wstb, 3'h1 << c)
         `CHK(dma_wr_byte_o, 8'hA0 + 8'(c))
         cyc(1'b0, 1'b1, 2'(c), 16'h0000, 8'h00);
         `CHK(rstb, 3'h1 << c)
         `CHK(rdata_o, 8'h5C ^ 8'(c))
      end
      close_out();
   end
endmodule
